// *** core/cycle_timer.v ***
// ****************************************************************
// self-timed busy cycle: load a count, run down, pulse done
// ****************************************************************
module cycle_timer #(
    parameter CW = 24
) (
    // clock and reset
    input  wire          ref_clk,
    input  wire          rst,
    // control
    input  wire          start,
    input  wire [CW-1:0] load,
    // status
    output reg           busy_reg,
    output reg           done_reg
);
    reg [CW-1:0] cnt_reg;   // cycles left

    // a start while busy is ignored; the caller never issues one
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_reg  <= {CW{1'b0}};
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (!busy_reg) begin
                if (start) begin
                    cnt_reg  <= load;
                    busy_reg <= 1'b1;
                end
            end else if (cnt_reg <= {{(CW-1){1'b0}}, 1'b1}) begin
                // last cycle: drop busy and flag completion once
                busy_reg <= 1'b0;
                done_reg <= 1'b1;
            end else begin
                cnt_reg <= cnt_reg - {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule // cycle_timer

// *** core/spi_flash_status_protect_id.v ***
// How it works
// - latch-clear command clears write enable latch
// - latch cleared at reset and after write operations
// - identity: maker, two device, length, sixteen data
// - factory data bytes read zero, read-only
// - identity read ignored while write cycle runs
// - identity bits change on falling clock edge
// - deselect returns to standby awaiting next select
// - status readable anytime, repeats while clocked
// - busy bit high exactly while cycle runs
// - writes refused while write enable latch clear
// - protect bits change only by status write
// - bulk erase only with protect bits zero
// - lock plus low pin: status bits locked
// - status write needs latch set beforehand
// - bits six, five, one, zero unwritable
// - status write cycle: busy, then clear latch
// - lock clear: status writable when latch set and no cycle running
// - lock set: writable only with pin high
// - protected mode either order; pin high exits
// - msb first, inputs taken on rising edge
`include "spi_flash_defs.vh"

module spi_flash_status_protect_id #(
    parameter [7:0]   MAKER_ID   = 8'hA5,    // arbitrary value
    parameter [7:0]   DEV_TYPE   = 8'h5A,    // arbitrary value
    parameter [7:0]   DEV_SIZE   = 8'h3C,    // arbitrary value
    parameter [127:0] FACTORY    = 128'h0,   // custom_factory_data
    parameter [23:0]  WSR_CYC    = `T_STAT_WRITE_NS / `CLK_PERIOD_NS,
    parameter [23:0]  PROG_CYC   = `T_PAGE_PROG_NS / `CLK_PERIOD_NS,
    parameter [23:0]  WIPE_CYC   = `T_REGION_NS / `CLK_PERIOD_NS,
    parameter [23:0]  BULK_CYC   = `T_BULK_NS / `CLK_PERIOD_NS
) (
    // clock and reset
    input  wire ref_clk,
    input  wire rst,
    // spi pins from the host
    input  wire sel_n,
    input  wire sclk,
    input  wire mosi,
    // protect pin
    input  wire protect_input_n,
    // serial data out, driven only while oe is high
    output reg  miso_reg,
    output reg  miso_oe_reg
);
    // ****************************************************************
    // states
    // ****************************************************************
    localparam [5:0] ST_IDLE = 6'h01;  // deselected, standby
    localparam [5:0] ST_CMD  = 6'h02;  // taking opcode
    localparam [5:0] ST_ID   = 6'h04;  // streaming identity
    localparam [5:0] ST_STAT = 6'h08;  // streaming status
    localparam [5:0] ST_ARGS = 6'h10;  // taking write arguments
    localparam [5:0] ST_IGN  = 6'h20;  // ignoring until deselect

    // ****************************************************************
    // pin synchronisation and edge finding
    // ****************************************************************
    wire [3:0] pins_s;        // synchronised sel, clk, data, protect
    wire       sel_n_s;       // synchronised select
    wire       sclk_s;        // synchronised serial clock
    wire       mosi_s;        // synchronised serial data
    wire       prot_n_s;      // synchronised protect pin
    reg        sclk_d_reg;    // serial clock one cycle late
    reg        sel_d_reg;     // select one cycle late
    wire       rise;          // serial clock rising
    wire       fall;          // serial clock falling
    wire       sel_start;     // select asserted
    wire       sel_end;       // select released

    sync2 #(.W(4)) u_sync (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .async_in ({sel_n, sclk, mosi, protect_input_n}),
        .sync_out (pins_s)
    );

    assign sel_n_s   = pins_s[3];
    assign sclk_s    = pins_s[2];
    assign mosi_s    = pins_s[1];
    assign prot_n_s  = pins_s[0];
    assign rise      = sclk_s & ~sclk_d_reg & ~sel_n_s;
    assign fall      = ~sclk_s & sclk_d_reg & ~sel_n_s;
    assign sel_start = ~sel_n_s & sel_d_reg;
    assign sel_end   = sel_n_s & ~sel_d_reg;

    // delayed copies for edge detection; read after the second stage only
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sclk_d_reg <= 1'b1;
            sel_d_reg  <= 1'b1;
        end else begin
            sclk_d_reg <= sclk_s;
            sel_d_reg  <= sel_n_s;
        end
    end

    // ****************************************************************
    // registers of the command engine
    // ****************************************************************
    reg [5:0] state_reg;     // one-hot state
    reg [7:0] in_shift_reg;  // incoming bits
    reg [2:0] bit_cnt_reg;   // rising edges modulo eight
    reg [2:0] byte_cnt_reg;  // whole bytes, saturating at 7
    reg [7:0] opcode_reg;    // decoded opcode
    reg [7:0] arg_reg;       // second byte (status write data)
    reg [7:0] out_shift_reg; // outgoing bits
    reg [4:0] id_idx_reg;    // next identity byte
    reg       wel_reg;       // write_enable_latch
    reg       lock_reg;      // status_write_lock, non-volatile
    reg [2:0] bp_reg;        // block_protect_bits, non-volatile
    reg       wsr_op_reg;    // running cycle is a status write
    reg [7:0] pend_reg;      // status byte waiting for cycle end
    reg       start_reg;     // one-cycle timer start
    reg [23:0] load_reg;     // timer count

    wire       busy;         // write_in_progress
    wire       done;         // cycle finished
    wire [7:0] in_byte;      // byte completed on this edge
    wire       hardware_protected_mode;          // hardware_protected_mode
    wire [7:0] status_byte;  // status as read
    wire [7:0] next_out;     // byte loaded at a byte boundary
    wire       boundary;     // whole bytes since select
    wire       can_write;    // latch set, no cycle running
    wire       arr_ok;       // array writes allowed

    assign in_byte = {in_shift_reg[6:0], mosi_s};
    // pure level: holds while lock is one and pin low, in either order
    assign hardware_protected_mode = lock_reg & ~prot_n_s;
    // b6 and b5 always zero
    assign status_byte = {lock_reg, 2'b00, bp_reg, wel_reg, busy};
    assign boundary  = (bit_cnt_reg == 3'h0);
    assign can_write = wel_reg & ~busy;
    // any set protect bit guards every array write: region map not modelled
    assign arr_ok    = can_write & (bp_reg == 3'h0);

    // identity byte by index; past the last byte the line reads zero
    function [7:0] id_byte;
        input [4:0] idx;
        reg   [4:0] off;
        begin
            off = 5'h0;
            case (idx)
                5'h00: id_byte = MAKER_ID;
                5'h01: id_byte = DEV_TYPE;
                5'h02: id_byte = DEV_SIZE;
                5'h03: id_byte = `ID_LEN_BYTE;
                default: begin
                    if (idx <= `ID_LAST_IDX) begin
                        off     = `ID_LAST_IDX - idx;
                        id_byte = FACTORY[{off[3:0], 3'b000} +: 8];
                    end else begin
                        id_byte = 8'h00;
                    end
                end
            endcase
        end
    endfunction

    assign next_out = (state_reg == ST_ID) ? id_byte(id_idx_reg) : status_byte;

    // ****************************************************************
    // self-timed cycle
    // ****************************************************************
    cycle_timer #(.CW(24)) u_timer (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .start    (start_reg),
        .load     (load_reg),
        .busy_reg (busy),
        .done_reg (done)
    );

    // ****************************************************************
    // command engine
    // ****************************************************************
    // single process so that latch set and clear sources are ordered here
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg     <= ST_IDLE;
            in_shift_reg  <= 8'h00;
            bit_cnt_reg   <= 3'h0;
            byte_cnt_reg  <= 3'h0;
            opcode_reg    <= 8'h00;
            arg_reg       <= 8'h00;
            out_shift_reg <= 8'h00;
            id_idx_reg    <= 5'h00;
            wel_reg       <= 1'b0;
            lock_reg      <= `SR_LOCK_RESET;
            bp_reg        <= `SR_BP_RESET;
            wsr_op_reg    <= 1'b0;
            pend_reg      <= 8'h00;
            start_reg     <= 1'b0;
            load_reg      <= 24'h0;
            miso_reg      <= 1'b0;
            miso_oe_reg   <= 1'b0;
        end else begin
            start_reg <= 1'b0;
            // cycle end: apply status, drop latch
            if (done) begin
                wel_reg <= 1'b0;
                if (wsr_op_reg) begin
                    lock_reg <= pend_reg[`SR_LOCK_BIT];
                    bp_reg   <= pend_reg[`SR_BP_MSB:`SR_BP_LSB];
                end
            end
            if (sel_n_s) begin
                // standby: any frame in flight is dropped
                state_reg   <= ST_IDLE;
                miso_oe_reg <= 1'b0;
                if (sel_end && state_reg == ST_ARGS && boundary) begin
                    // execute on release at a byte boundary only
                    case (opcode_reg)
                        `OP_LATCH_SET: begin
                            if (byte_cnt_reg == `LEN_SHORT && !busy)
                                wel_reg <= 1'b1;
                        end
                        `OP_LATCH_CLEAR: begin
                            if (byte_cnt_reg == `LEN_SHORT)
                                wel_reg <= 1'b0;
                        end
                        `OP_STAT_WRITE: begin
                            // exactly one data byte, latch set, not locked
                            if (byte_cnt_reg == `LEN_STAT_WRITE && can_write
                                && !hardware_protected_mode) begin
                                pend_reg   <= arg_reg;
                                wsr_op_reg <= 1'b1;
                                load_reg   <= WSR_CYC;
                                start_reg  <= 1'b1;
                            end
                        end
                        `OP_PAGE_PROG: begin
                            if (byte_cnt_reg >= `LEN_PROG_MIN && arr_ok) begin
                                wsr_op_reg <= 1'b0;
                                load_reg   <= PROG_CYC;
                                start_reg  <= 1'b1;
                            end
                        end
                        `OP_REGION_WIPE: begin
                            if (byte_cnt_reg == `LEN_WIPE && arr_ok) begin
                                wsr_op_reg <= 1'b0;
                                load_reg   <= WIPE_CYC;
                                start_reg  <= 1'b1;
                            end
                        end
                        `OP_BULK_ERASE: begin
                            if (byte_cnt_reg == `LEN_SHORT && arr_ok) begin
                                wsr_op_reg <= 1'b0;
                                load_reg   <= BULK_CYC;
                                start_reg  <= 1'b1;
                            end
                        end
                        default: begin
                            state_reg <= ST_IDLE;
                        end
                    endcase
                end
            end else begin
                if (sel_start) begin
                    // fresh frame: clear counters
                    state_reg    <= ST_CMD;
                    bit_cnt_reg  <= 3'h0;
                    byte_cnt_reg <= 3'h0;
                    id_idx_reg   <= 5'h00;
                end
                if (rise) begin
                    // msb first, taken on rising edges
                    in_shift_reg <= in_byte;
                    bit_cnt_reg  <= bit_cnt_reg + 3'h1;
                    if (bit_cnt_reg == 3'h7) begin
                        if (byte_cnt_reg != 3'h7)
                            byte_cnt_reg <= byte_cnt_reg + 3'h1;
                        if (state_reg == ST_CMD) begin
                            opcode_reg <= in_byte;
                            if (in_byte == `OP_STAT_READ)
                                state_reg <= ST_STAT;
                            else if (busy)
                                state_reg <= ST_IGN;
                            else if (in_byte == `OP_IDENT_READ)
                                state_reg <= ST_ID;
                            else
                                state_reg <= ST_ARGS;
                        end else if (state_reg == ST_ARGS
                                     && byte_cnt_reg == `LEN_SHORT) begin
                            arg_reg <= in_byte;
                        end
                    end
                end
                if (fall && (state_reg == ST_ID || state_reg == ST_STAT)) begin
                    // output bits change on falling edges only
                    miso_oe_reg <= 1'b1;
                    if (boundary) begin
                        // status reloads live each byte, so it repeats
                        miso_reg      <= next_out[7];
                        out_shift_reg <= {next_out[6:0], 1'b0};
                        if (state_reg == ST_ID && id_idx_reg != `ID_END_IDX)
                            id_idx_reg <= id_idx_reg + 5'h01;
                    end else begin
                        miso_reg      <= out_shift_reg[7];
                        out_shift_reg <= {out_shift_reg[6:0], 1'b0};
                    end
                end
            end
        end
    end
endmodule // spi_flash_status_protect_id

// *** core/sync2.v ***
// ****************************************************************
// two-stage synchroniser, one lane per bit
// ****************************************************************
module sync2 #(
    parameter W = 4
) (
    // clock and reset
    input  wire         ref_clk,
    input  wire         rst,
    // asynchronous levels in, synchronised levels out
    input  wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_lane
            reg meta_reg;   // first stage, read only by second
            reg safe_reg;   // second stage
            // both stages reset high: idle select and protect pins sit high
            always @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    meta_reg <= 1'b1;
                    safe_reg <= 1'b1;
                end else begin
                    meta_reg <= async_in[i];
                    safe_reg <= meta_reg;
                end
            end
            assign sync_out[i] = safe_reg;
        end
    endgenerate
endmodule // sync2

// *** pkg/spi_flash_defs.vh ***
`ifndef SPI_FLASH_DEFS_VH
`define SPI_FLASH_DEFS_VH

// ****************************************************************
// opcodes
// ****************************************************************
`define OP_LATCH_SET    8'h06
`define OP_LATCH_CLEAR  8'h04
`define OP_IDENT_READ   8'h9F
`define OP_STAT_READ    8'h05
`define OP_STAT_WRITE   8'h01
`define OP_PAGE_PROG    8'h02
`define OP_REGION_WIPE  8'hD8
`define OP_BULK_ERASE   8'hC7

// ****************************************************************
// status byte layout
// ****************************************************************
`define SR_WIP_BIT      0
`define SR_WEL_BIT      1
`define SR_BP_LSB       2
`define SR_BP_MSB       4
`define SR_LOCK_BIT     7
`define SR_LOCK_RESET   1'h0
`define SR_BP_RESET     3'h0

// ****************************************************************
// identity stream
// ****************************************************************
`define ID_LEN_BYTE     8'h10
`define ID_LAST_IDX     5'h13
`define ID_END_IDX      5'h14

// ****************************************************************
// command lengths in bytes, opcode included
// ****************************************************************
`define LEN_SHORT       3'h1
`define LEN_STAT_WRITE  3'h2
`define LEN_WIPE        3'h4
`define LEN_PROG_MIN    3'h5

// ****************************************************************
// self-timed cycles, times in ns at an 8 ns clock
// ****************************************************************
`define CLK_PERIOD_NS   24'h8
`define T_STAT_WRITE_NS 24'h3A98
`define T_PAGE_PROG_NS  24'h9C400
`define T_REGION_NS     24'h927C0
`define T_BULK_NS       24'h13D620

`endif

// *** test/flash_props.sv ***
// ****************************************************************
// port-level checks on the serial answer path
// ****************************************************************
module flash_props (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // spi pins and protect pin
    input wire logic sel_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic protect_input_n,
    // answer to the host
    input wire logic miso_reg,
    input wire logic miso_oe_reg
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // select pin seen high long enough to pass the synchroniser
    sequence desel_seen;
        sel_n [*6];
    endsequence
    // a new output bit launched while driving
    sequence bit_launch;
        $changed(miso_reg) && miso_oe_reg;
    endsequence
    quiet_after_reset_a: assert property ($fell(rst) |-> !miso_oe_reg [*3])
        else $error("output enabled right after reset");
    desel_release_a: assert property (desel_seen |-> !miso_oe_reg)
        else $error("output still enabled after deselect");
    idle_no_drive_a: assert property (sel_n |=> !$rose(miso_oe_reg))
        else $error("output enabled while deselected");
    oe_needs_sel_a: assert property ($rose(miso_oe_reg) |-> !$past(sel_n, 2))
        else $error("output enabled without selection");
    oe_on_fall_a: assert property ($rose(miso_oe_reg) |-> !$past(sclk, 3))
        else $error("output enabled away from a falling clock");
    bit_on_fall_a: assert property (bit_launch |-> !$past(sclk, 3))
        else $error("output bit changed away from a falling clock");
    bit_hold_a: assert property (sclk [*6] |-> $stable(miso_reg))
        else $error("output bit moved while serial clock high");
    oe_stays_a: assert property (miso_oe_reg && !sel_n |=> miso_oe_reg)
        else $error("output dropped while still selected");
endmodule // flash_props

bind spi_flash_status_protect_id flash_props props_u (
    .ref_clk, .rst, .sel_n, .sclk, .mosi, .protect_input_n, .miso_reg, .miso_oe_reg
);

// *** test/spi_host_model.sv ***
// ****************************************************************
// spi host, mode 0, 125 ns link clock
// ****************************************************************
module spi_host_model (
    // link to the device
    output logic sel_n,
    output logic sclk,
    output logic mosi,
    // answer from the device
    input  logic miso_reg,
    input  logic miso_oe_reg,
    // system clock, only to start frames off its edge
    input  logic ref_clk
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam realtime HALF = 62.5; // half of the link period
    logic drove;                     // device drove at any sample of the frame
    initial begin
        sel_n = 1'b1;
        sclk  = 1'b0;
        mosi  = 1'b0;
        drove = 1'b0;
    end
    // select; the clock stays low between frames
    task automatic open_frame();
        @(negedge ref_clk);
        sel_n = 1'b0;
        drove = 1'b0;
        // a quarter step keeps every link edge off the system clock edges
        #(HALF + 0.25);
    endtask
    // msb first, data taken at the rising edge
    task automatic shift(input logic [7:0] o, input int n, output logic [7:0] i);
        i = 8'h00;
        for (int k = 0; k < n; k++) begin
            mosi = o[7-k];
            #(HALF);
            sclk = 1'b1;
            // undriven line reads as the inverse of the last bit, never a lucky match
            i = {i[6:0], miso_oe_reg ? miso_reg : ~i[0]};
            drove = drove | miso_oe_reg;
            #(HALF);
            sclk = 1'b0;
        end
    endtask
    // deselect; whole bytes are the caller's duty
    task automatic close_frame();
        #(HALF);
        sel_n = 1'b1;
        mosi = ~mosi;
        #(4*HALF);
    endtask
endmodule // spi_host_model

// *** test/tb_top.sv ***
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam [23:0] CYC     = 24'h0003E8;     // shortened self-timed cycle, 8 us
    localparam [31:0] ID_HEAD = 32'hC36B2E10;   // arbitrary ids, then length 10h
    logic       ref_clk;                        // system clock
    logic       rst;                            // async reset
    logic       protect_input_n;                // protect pin
    wire        sel_n, sclk, mosi;              // link from the host
    wire        miso_reg, miso_oe_reg;          // answer
    logic [7:0] s;                              // last status or data byte
    int         miscompares, n_checks, ticks;   // counters
    spi_flash_status_protect_id #(.MAKER_ID(ID_HEAD[31:24]), .DEV_TYPE(ID_HEAD[23:16]),
        .DEV_SIZE(ID_HEAD[15:8]), .WSR_CYC(CYC), .PROG_CYC(CYC), .WIPE_CYC(CYC),
        .BULK_CYC(CYC)) dut_u (.ref_clk(ref_clk), .rst(rst), .sel_n(sel_n), .sclk(sclk),
        .mosi(mosi), .protect_input_n(protect_input_n), .miso_reg(miso_reg),
        .miso_oe_reg(miso_oe_reg));
    spi_host_model host_u (.sel_n(sel_n), .sclk(sclk), .mosi(mosi), .miso_reg(miso_reg),
        .miso_oe_reg(miso_oe_reg), .ref_clk(ref_clk));
    // ****************************************************************
    // shared tasks
    // ****************************************************************
    // free-running system clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // a hang ends the run as a failure
    always @(posedge ref_clk) begin
        ticks++;
        if (ticks == 60000) begin
            miscompares++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // opcode, then bits of repeated data; a count off the byte grid cuts a byte short
    task automatic send(input logic [7:0] op, input logic [7:0] dat, input int bits);
        logic [7:0] d;
        host_u.open_frame();
        host_u.shift(op, 8, d);
        for (int b = bits; b > 0; b -= 8)
            host_u.shift(dat, (b < 8) ? b : 8, d);
        host_u.close_frame();
    endtask
    task automatic status(output logic [7:0] v);
        send(8'h05, 8'h00, 0);
        host_u.open_frame();
        host_u.shift(8'h05, 8, v);
        host_u.shift(8'h00, 8, v);
        host_u.close_frame();
    endtask
    // poll busy before the next command, bounded
    task automatic idle();
        int n;
        n = 0;
        do begin
            status(s);
            n++;
        end while (s[0] !== 1'b0 && n < 20);
        chk("busy cleared", {7'h00, s[0]}, 8'h00);
    endtask
    task automatic step(input logic [7:0] op, input logic [7:0] dat, input int bits,
                        input logic [7:0] exp, input string what);
        send(op, dat, bits);
        idle();
        chk(what, s, exp);
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_latch();
        status(s);
        chk("status after reset", s, 8'h00);
        step(8'h06, 8'h00, 0, 8'h02, "latch set");
        step(8'h04, 8'h00, 3, 8'h02, "partial clear");
        step(8'h04, 8'h00, 0, 8'h00, "latch clear");
        step(8'h01, 8'h1C, 8, 8'h00, "write without latch");
        step(8'h06, 8'h00, 0, 8'h02, "latch set again");
        step(8'h01, 8'h1C, 5, 8'h02, "short status write");
        step(8'h01, 8'h1C, 16, 8'h02, "long status write");
    endtask
    task automatic t_ident();
        host_u.open_frame();
        host_u.shift(8'h9F, 8, s);
        for (int i = 0; i < 20; i++) begin
            host_u.shift(8'h00, 8, s);
            chk("identity byte", s, (i < 4) ? ID_HEAD[31-8*i -: 8] : 8'h00);
        end
        host_u.close_frame();
        send(8'h9F, 8'h00, 13);
        status(s);
        chk("standby after early end", s, 8'h02);
    endtask
    // one frame reads status across the whole write cycle
    task automatic t_cycle();
        int n;
        send(8'h01, 8'hFF, 8);
        host_u.open_frame();
        host_u.shift(8'h05, 8, s);
        host_u.shift(8'h00, 8, s);
        chk("status in cycle", s, 8'h03);
        n = 0;
        while (s[0] === 1'b1 && n < 30) begin
            host_u.shift(8'h00, 8, s);
            n++;
        end
        chk("status after cycle", s, 8'h9C);
        host_u.close_frame();
    endtask
    task automatic t_protect();
        step(8'h06, 8'h00, 0, 8'h9E, "latch under protection");
        step(8'hC7, 8'h00, 0, 8'h9E, "bulk erase refused");
        step(8'h02, 8'h00, 32, 8'h9E, "program refused");
        step(8'hD8, 8'h00, 24, 8'h9E, "wipe refused");
        @(negedge ref_clk) protect_input_n = 1'b0;
        step(8'h01, 8'h00, 8, 8'h9E, "locked write refused");
        @(negedge ref_clk) protect_input_n = 1'b1;
        step(8'h01, 8'h00, 8, 8'h00, "pin high write");
        @(negedge ref_clk) protect_input_n = 1'b0;
        step(8'h06, 8'h00, 0, 8'h02, "latch with pin low");
        step(8'h01, 8'h80, 8, 8'h80, "lock set pin low");
        step(8'h06, 8'h00, 0, 8'h82, "latch while locked");
        step(8'h01, 8'h00, 8, 8'h82, "late lock protects");
        @(negedge ref_clk) protect_input_n = 1'b1;
        step(8'h01, 8'h00, 8, 8'h00, "pin high leaves");
    endtask
    task automatic t_busy();
        logic [7:0] ops [3];
        int         bits [3];
        ops = '{8'hC7, 8'hD8, 8'h02};
        bits = '{0, 24, 32};
        for (int k = 0; k < 3; k++) begin
            send(8'h06, 8'h00, 0);
            send(ops[k], 8'h00, bits[k]);
            send(8'h9F, 8'h00, 16);
            chk("identity in cycle", {7'h00, host_u.drove}, 8'h00);
            status(s);
            chk("busy in cycle", {7'h00, s[0]}, 8'h01);
            idle();
            chk("latch after cycle", s, 8'h00);
        end
    endtask
    // reset, scenarios, a mid-run reset, then the verdict
    initial begin
        rst = 1'b1;
        protect_input_n = 1'b1;
        miscompares = 0;
        n_checks = 0;
        ticks = 0;
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk) rst = 1'b0;
        repeat (3) @(negedge ref_clk);
        t_latch();
        t_ident();
        t_cycle();
        t_protect();
        t_busy();
        send(8'h06, 8'h00, 0);
        @(negedge ref_clk) rst = 1'b1;
        repeat (4) @(negedge ref_clk);
        rst = 1'b0;
        repeat (3) @(negedge ref_clk);
        status(s);
        chk("status after second reset", s, 8'h00);
        final_report();
    end
endmodule // tb_top
